// ==== design/pin_select_map.svh ====
/*
  Field code, width and reset constants for the port pin function selector.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH
`define CHIP_SELECT_HIGH_CODE 3'h4
`define PORT_CODE             3'h0
`define ANALOG_SEL_WIDTH      4
`define ANALOG_SEL_RESET      4'h0
`endif

// ==== design/pin_select_pkg.sv ====
/*
  Types for the port pin function selector.
  Assumes the constant header is on the include path.
*/
`include "pin_select_map.svh"
package pin_select_pkg;
  typedef enum logic [2:0] {
    B6_PORT = 3'h1,
    B6_CSH  = 3'h2,
    B6_DACK = 3'h4
  } b6_func_e;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_s;

  typedef struct packed {
    logic chip_select1_high_enable;
    logic ack_select_ch2;
    logic ack_drive_ch2;
  } b6_sel_s;
endpackage

// ==== design/port_pin_function_select.sv ====
/*
  Pin-function multiplexer for port B bits 5/6, port E bits 0..5, port F bits 0..5.
  Assumes selects and peripheral signals are synchronous to clock; tristate
  wires resolved outside from output enables.
*/
// What this block does
// - Port B bit 5 pin level always goes to DMA request input of channel 2.
// - Port B bit 6 is port at select 000, chip select high at 100, else DMA acknowledge 2.
// - Port E bits 0 and 1 always go to external interrupt inputs 0 and 1.
// - Port E bits 2/3 feed serial clock inputs 1/2 when clock enable is 0, drive them when 1.
// - Port E bits 4 and 5 always go to DMA request inputs of channels 0 and 1.
// - Port F bit 0 goes to serial input 0 and timer trigger 0.
// - Port F bit 1 is port or serial output 0 by output enable, and feeds timer trigger 1.
// - Port F bit 2 feeds serial clock 0 input when clock enable is 0, drives it when 1.
// - Port F bit 3 goes to serial input 1 and timer trigger 2.
// - Port F bit 4 feeds timer trigger 3 and is port or serial output 1 by output enable.
// - Port F bit 5 feeds serial input 2 and is port or compare output 1 by pin enable.
`timescale 1ns/1ps
`include "pin_select_map.svh"
module port_pin_function_select
  import pin_select_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       chip_select1_low_enable,
  input  wire b6_sel_s    b6_sel,
  input  wire logic       serial_clock_out_enable,
  input  wire logic       serial_out_enable,
  input  wire logic       compare_output_pin_enable,
  input  wire logic [3:0] analog_sel,
  input  wire logic [1:0] port_b_out,
  input  wire logic [1:0] port_b_oe,
  input  wire logic [5:0] port_e_out,
  input  wire logic [5:0] port_e_oe,
  input  wire logic [5:0] port_f_out,
  input  wire logic [5:0] port_f_oe,
  input  wire logic       chip_select1_low,
  input  wire logic       chip_select1_high,
  input  wire logic       dma_acknowledge_ch2,
  input  wire logic [2:0] serial_clock_out,
  input  wire logic       serial_output0,
  input  wire logic       serial_output1,
  input  wire logic       compare_output1,
  input  wire logic [1:0] port_b_in,
  input  wire logic [5:0] port_e_in,
  input  wire logic [5:0] port_f_in,
  output logic      [1:0] port_b_pin_o,
  output logic      [1:0] port_b_pin_oe,
  output logic      [5:0] port_e_pin_o,
  output logic      [5:0] port_e_pin_oe,
  output logic      [5:0] port_f_pin_o,
  output logic      [5:0] port_f_pin_oe,
  output logic      [2:0] dma_request,
  output logic      [1:0] ext_irq_input,
  output logic      [2:0] serial_clock_in,
  output logic      [2:0] serial_input,
  output logic      [3:0] timer_trigger,
  output logic            analog_select_error
);
  logic [1:0] port_b_pin_o_r;
  logic [1:0] port_b_pin_oe_r;
  logic [5:0] port_e_pin_o_r;
  logic [5:0] port_e_pin_oe_r;
  logic [5:0] port_f_pin_o_r;
  logic [5:0] port_f_pin_oe_r;
  logic [2:0] dma_request_r;
  logic [1:0] ext_irq_input_r;
  logic [2:0] serial_clock_in_r;
  logic [2:0] serial_input_r;
  logic [3:0] timer_trigger_r;
  logic       analog_select_error_r;

  function automatic pin_drive_s pick(input logic alt, input logic alt_o,
                                      input logic p_o, input logic p_oe);
    pick = alt ? pin_drive_s'{o: alt_o, oe: 1'b1} : pin_drive_s'{o: p_o, oe: p_oe};
  endfunction

  // Port B bit 6 selection
  wire        b6_is_port = (b6_sel == `PORT_CODE);
  wire        b6_is_csh  = (b6_sel == `CHIP_SELECT_HIGH_CODE);
  b6_func_e   b6_func;
  assign b6_func = b6_is_port ? B6_PORT : (b6_is_csh ? B6_CSH : B6_DACK);
  wire        b6_alt_o = (b6_func == B6_CSH) ? chip_select1_high : dma_acknowledge_ch2;

  // Pin drives; alternate function takes the pin from the port driver
  wire pin_drive_s b5_d  = pick(chip_select1_low_enable, chip_select1_low,
                                port_b_out[0], port_b_oe[0]);
  wire pin_drive_s b6_d  = pick(!b6_is_port, b6_alt_o,
                                port_b_out[1], port_b_oe[1]);
  wire pin_drive_s pe2_d = pick(serial_clock_out_enable, serial_clock_out[1],
                                port_e_out[2], port_e_oe[2]);
  wire pin_drive_s pe3_d = pick(serial_clock_out_enable, serial_clock_out[2],
                                port_e_out[3], port_e_oe[3]);
  wire pin_drive_s pf1_d = pick(serial_out_enable, serial_output0,
                                port_f_out[1], port_f_oe[1]);
  wire pin_drive_s pf2_d = pick(serial_clock_out_enable, serial_clock_out[0],
                                port_f_out[2], port_f_oe[2]);
  wire pin_drive_s pf4_d = pick(serial_out_enable, serial_output1,
                                port_f_out[4], port_f_oe[4]);
  wire pin_drive_s pf5_d = pick(compare_output_pin_enable, compare_output1,
                                port_f_out[5], port_f_oe[5]);

  wire [1:0] port_b_pin_o_nxt  = {b6_d.o, b5_d.o};
  wire [1:0] port_b_pin_oe_nxt = {b6_d.oe, b5_d.oe};
  wire [5:0] port_e_pin_o_nxt  = {port_e_out[5:4], pe3_d.o, pe2_d.o, port_e_out[1:0]};
  wire [5:0] port_e_pin_oe_nxt = {port_e_oe[5:4], pe3_d.oe, pe2_d.oe, port_e_oe[1:0]};
  wire [5:0] port_f_pin_o_nxt  = {pf5_d.o, pf4_d.o, port_f_out[3], pf2_d.o, pf1_d.o,
                                  port_f_out[0]};
  wire [5:0] port_f_pin_oe_nxt = {pf5_d.oe, pf4_d.oe, port_f_oe[3], pf2_d.oe, pf1_d.oe,
                                  port_f_oe[0]};

  // Forwarded inputs
  wire [2:0] dma_request_nxt     = {port_b_in[0], port_e_in[5:4]};
  wire [1:0] ext_irq_input_nxt   = port_e_in[1:0];
  wire [2:0] serial_clock_in_nxt = serial_clock_out_enable ? 3'h0
                                   : {port_e_in[3:2], port_f_in[2]};
  wire [2:0] serial_input_nxt    = {port_f_in[5], port_f_in[3], port_f_in[0]};
  wire [3:0] timer_trigger_nxt   = {port_f_in[4], port_f_in[3], port_f_in[1], port_f_in[0]};
  wire       analog_err_nxt      = |analog_sel;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_b_pin_o_r        <= 2'h0;
      port_b_pin_oe_r       <= 2'h0;
      port_e_pin_o_r        <= 6'h00;
      port_e_pin_oe_r       <= 6'h00;
      port_f_pin_o_r        <= 6'h00;
      port_f_pin_oe_r       <= 6'h00;
      dma_request_r         <= 3'h0;
      ext_irq_input_r       <= 2'h0;
      serial_clock_in_r     <= 3'h0;
      serial_input_r        <= 3'h0;
      timer_trigger_r       <= 4'h0;
      analog_select_error_r <= 1'b0;
    end else begin
      port_b_pin_o_r        <= port_b_pin_o_nxt;
      port_b_pin_oe_r       <= port_b_pin_oe_nxt;
      port_e_pin_o_r        <= port_e_pin_o_nxt;
      port_e_pin_oe_r       <= port_e_pin_oe_nxt;
      port_f_pin_o_r        <= port_f_pin_o_nxt;
      port_f_pin_oe_r       <= port_f_pin_oe_nxt;
      dma_request_r         <= dma_request_nxt;
      ext_irq_input_r       <= ext_irq_input_nxt;
      serial_clock_in_r     <= serial_clock_in_nxt;
      serial_input_r        <= serial_input_nxt;
      timer_trigger_r       <= timer_trigger_nxt;
      analog_select_error_r <= analog_err_nxt;
    end
  end

  assign port_b_pin_o        = port_b_pin_o_r;
  assign port_b_pin_oe       = port_b_pin_oe_r;
  assign port_e_pin_o        = port_e_pin_o_r;
  assign port_e_pin_oe       = port_e_pin_oe_r;
  assign port_f_pin_o        = port_f_pin_o_r;
  assign port_f_pin_oe       = port_f_pin_oe_r;
  assign dma_request         = dma_request_r;
  assign ext_irq_input       = ext_irq_input_r;
  assign serial_clock_in     = serial_clock_in_r;
  assign serial_input        = serial_input_r;
  assign timer_trigger       = timer_trigger_r;
  assign analog_select_error = analog_select_error_r;

  // Checks; forwarded levels are only compared once a full cycle has run out of reset
  a_dma_req2_follow: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> dma_request[2] == $past(port_b_in[0]))
    else $error("dma request 2 not pin level");
  a_b6_port_mode: assert property (@(posedge clock) disable iff (!rst_n)
    (b6_sel == 3'h0) |=> (port_b_pin_o[1] == $past(port_b_out[1])
                          && port_b_pin_oe[1] == $past(port_b_oe[1])))
    else $error("port b bit 6 not port at 000");
  a_b6_csh_mode: assert property (@(posedge clock) disable iff (!rst_n)
    (b6_sel == 3'h4) |=> (port_b_pin_o[1] == $past(chip_select1_high) && port_b_pin_oe[1]))
    else $error("port b bit 6 not chip select high at 100");
  a_b6_dack_mode: assert property (@(posedge clock) disable iff (!rst_n)
    (b6_sel != 3'h0 && b6_sel != 3'h4) |=> (port_b_pin_o[1] == $past(dma_acknowledge_ch2)
                                            && port_b_pin_oe[1]))
    else $error("port b bit 6 not dma ack");
  a_irq_follows_pin: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> ext_irq_input == $past(port_e_in[1:0]))
    else $error("irq input mismatch");
  a_sclk_out_drive: assert property (@(posedge clock) disable iff (!rst_n)
    serial_clock_out_enable |=> (port_e_pin_oe[3:2] == 2'h3 && port_f_pin_oe[2]))
    else $error("serial clock pins not driven");
  a_sclk_out_value: assert property (@(posedge clock) disable iff (!rst_n)
    serial_clock_out_enable |=> (port_e_pin_o[3:2] == $past(serial_clock_out[2:1])
                                 && port_f_pin_o[2] == $past(serial_clock_out[0])))
    else $error("serial clock pin value mismatch");
  a_sclk_in_feed: assert property (@(posedge clock) disable iff (!rst_n)
    !serial_clock_out_enable |=> (serial_clock_in[0] == $past(port_f_in[2])))
    else $error("serial clock 0 input mismatch");
  a_sclk_in_port_e: assert property (@(posedge clock) disable iff (!rst_n)
    !serial_clock_out_enable |=> (serial_clock_in[2:1] == $past(port_e_in[3:2])))
    else $error("serial clock 1/2 input mismatch");
  a_dreq01_follow: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> dma_request[1:0] == $past(port_e_in[5:4]))
    else $error("dma request 0/1 mismatch");
  a_trig_serial_in: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> (timer_trigger[0] == $past(port_f_in[0]))
                     && (serial_input[0] == $past(port_f_in[0])))
    else $error("trigger 0 or serial input 0 mismatch");
  a_serial_in1: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> (serial_input[1] == $past(port_f_in[3]))
                     && (timer_trigger[2] == $past(port_f_in[3])))
    else $error("trigger 2 or serial input 1 mismatch");
  a_trig1_follow: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> timer_trigger[1] == $past(port_f_in[1]))
    else $error("trigger 1 mismatch");
  a_sout_select: assert property (@(posedge clock) disable iff (!rst_n)
    serial_out_enable |=> (port_f_pin_o[1] == $past(serial_output0) && port_f_pin_oe[1]))
    else $error("serial output 0 not driven");
  a_port_f1_keep: assert property (@(posedge clock) disable iff (!rst_n)
    !serial_out_enable |=> (port_f_pin_o[1] == $past(port_f_out[1])
                            && port_f_pin_oe[1] == $past(port_f_oe[1])))
    else $error("port f bit 1 not port");
  a_trig3_follow: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> timer_trigger[3] == $past(port_f_in[4]))
    else $error("trigger 3 mismatch");
  a_sout1_select: assert property (@(posedge clock) disable iff (!rst_n)
    serial_out_enable |=> (port_f_pin_o[4] == $past(serial_output1) && port_f_pin_oe[4]))
    else $error("serial output 1 not driven");
  a_serial_in2: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> serial_input[2] == $past(port_f_in[5]))
    else $error("serial input 2 mismatch");
  a_cmp_out_select: assert property (@(posedge clock) disable iff (!rst_n)
    compare_output_pin_enable |=> (port_f_pin_o[5] == $past(compare_output1)
                                   && port_f_pin_oe[5]))
    else $error("compare output 1 not driven");
  a_port_disconnect: assert property (@(posedge clock) disable iff (!rst_n)
    (serial_out_enable && !port_f_out[4] && serial_output1) |=> port_f_pin_o[4])
    else $error("port driver still on pin");
  a_analog_flag: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> analog_select_error == (|$past(analog_sel)))
    else $error("analog select flag mismatch");

  c_b6_dack: cover property (@(posedge clock) disable iff (!rst_n) b6_sel == 3'h3);
  c_b6_csh:  cover property (@(posedge clock) disable iff (!rst_n) b6_sel == 3'h4);
  c_sclk_out: cover property (@(posedge clock) disable iff (!rst_n) serial_clock_out_enable);
  c_analog_err: cover property (@(posedge clock) disable iff (!rst_n) analog_select_error);
endmodule // port_pin_function_select

// ==== sim/pin_peer_model.sv ====
/*
  Pin-side model: resolves each port pin from the block's drive and an outside level.
  Assumes the bench supplies the outside levels, bit order {F, E, B}.
*/
`timescale 1ns/1ps
module pin_peer_model (
  input  wire logic [13:0] pin_o,
  input  wire logic [13:0] pin_oe,
  input  wire logic [13:0] ext_lvl,
  output logic      [13:0] pin_lvl
);
  // Driven pin shows the block's value, released pin the outside level
  assign pin_lvl = (pin_o & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // pin_peer_model

// ==== sim/tb_top.sv ====
/*
  Self-checking bench for the port pin function selector.
  Assumes every output answers one clock after the inputs it samples.
*/
`timescale 1ns/1ps
module tb_top
  import pin_select_pkg::*;
;
  logic        clock, rst_n, chip_select1_low_enable, serial_clock_out_enable;
  logic        serial_out_enable, compare_output_pin_enable, chip_select1_low;
  logic        chip_select1_high, dma_acknowledge_ch2, serial_output0, serial_output1;
  logic        compare_output1, analog_select_error;
  b6_sel_s     b6_sel;
  logic [3:0]  analog_sel, timer_trigger;
  logic [1:0]  port_b_out, port_b_oe, port_b_in, port_b_pin_o, port_b_pin_oe, ext_irq_input;
  logic [5:0]  port_e_out, port_e_oe, port_e_in, port_e_pin_o, port_e_pin_oe;
  logic [5:0]  port_f_out, port_f_oe, port_f_in, port_f_pin_o, port_f_pin_oe;
  logic [2:0]  serial_clock_out, dma_request, serial_clock_in, serial_input;
  logic [13:0] ext_lvl, pin_lvl;
  logic [43:0] got, exp_q;
  int          n_fail, n_checks;
  bit          armed;

  assign {port_f_in, port_e_in, port_b_in} = pin_lvl;
  assign got = {port_f_pin_o, port_e_pin_o, port_b_pin_o, port_f_pin_oe, port_e_pin_oe,
                port_b_pin_oe, dma_request, ext_irq_input, serial_clock_in, serial_input,
                timer_trigger, analog_select_error};

  port_pin_function_select port_pin_function_select_i (
    .clock                     (clock),
    .rst_n                     (rst_n),
    .chip_select1_low_enable   (chip_select1_low_enable),
    .b6_sel                    (b6_sel),
    .serial_clock_out_enable   (serial_clock_out_enable),
    .serial_out_enable         (serial_out_enable),
    .compare_output_pin_enable (compare_output_pin_enable),
    .analog_sel                (analog_sel),
    .port_b_out                (port_b_out),
    .port_b_oe                 (port_b_oe),
    .port_e_out                (port_e_out),
    .port_e_oe                 (port_e_oe),
    .port_f_out                (port_f_out),
    .port_f_oe                 (port_f_oe),
    .chip_select1_low          (chip_select1_low),
    .chip_select1_high         (chip_select1_high),
    .dma_acknowledge_ch2       (dma_acknowledge_ch2),
    .serial_clock_out          (serial_clock_out),
    .serial_output0            (serial_output0),
    .serial_output1            (serial_output1),
    .compare_output1           (compare_output1),
    .port_b_in                 (port_b_in),
    .port_e_in                 (port_e_in),
    .port_f_in                 (port_f_in),
    .port_b_pin_o              (port_b_pin_o),
    .port_b_pin_oe             (port_b_pin_oe),
    .port_e_pin_o              (port_e_pin_o),
    .port_e_pin_oe             (port_e_pin_oe),
    .port_f_pin_o              (port_f_pin_o),
    .port_f_pin_oe             (port_f_pin_oe),
    .dma_request               (dma_request),
    .ext_irq_input             (ext_irq_input),
    .serial_clock_in           (serial_clock_in),
    .serial_input              (serial_input),
    .timer_trigger             (timer_trigger),
    .analog_select_error       (analog_select_error)
  );
  pin_peer_model pin_peer_model_i (
    .pin_o   ({port_f_pin_o, port_e_pin_o, port_b_pin_o}),
    .pin_oe  ({port_f_pin_oe, port_e_pin_oe, port_b_pin_oe}),
    .ext_lvl (ext_lvl),
    .pin_lvl (pin_lvl)
  );

  task automatic chk(input logic [43:0] g, input logic [43:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic drive(input int k);
    logic [31:0] v;
    v = 32'(k) * 32'h9e37_79b1;
    {compare_output_pin_enable, serial_out_enable, serial_clock_out_enable, b6_sel} = 6'(k);
    chip_select1_low_enable = v[7];
    {port_f_out, port_e_out, port_b_out} = v[13:0];
    {port_f_oe, port_e_oe, port_b_oe} = v[27:14];
    {chip_select1_low, chip_select1_high, dma_acknowledge_ch2, serial_clock_out,
     serial_output0, serial_output1, compare_output1} = v[31:23];
    ext_lvl = ~v[20:7];
    analog_sel = (k == 37) ? 4'h8 : 4'h0;
  endtask

  task automatic calc();
    logic [13:0] o, oe, l;
    o = {port_f_out, port_e_out, port_b_out};
    oe = {port_f_oe, port_e_oe, port_b_oe};
    l = pin_lvl;
    if (chip_select1_low_enable) {o[0], oe[0]} = {chip_select1_low, 1'b1};
    if (b6_sel != 3'h0) begin
      o[1] = (b6_sel == 3'h4) ? chip_select1_high : dma_acknowledge_ch2;
      oe[1] = 1'b1;
    end
    if (serial_clock_out_enable) begin
      {o[5], o[4], o[10]} = serial_clock_out;
      {oe[5], oe[4], oe[10]} = 3'h7;
    end
    if (serial_out_enable) begin
      {o[12], o[9]} = {serial_output1, serial_output0};
      {oe[12], oe[9]} = 2'h3;
    end
    if (compare_output_pin_enable) {o[13], oe[13]} = {compare_output1, 1'b1};
    exp_q = {o, oe, l[0], l[7], l[6], l[3], l[2],
             serial_clock_out_enable ? 3'h0 : {l[5], l[4], l[10]},
             l[13], l[11], l[8], l[12], l[11], l[9], l[8], |analog_sel};
  endtask

  task automatic step(input int k);
    @(negedge clock);
    if (armed) chk(got, exp_q, "pin map");
    drive(k);
    #1;
    calc();
    armed = 1'b1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    rst_n = 1'b0;
    armed = 1'b0;
    drive(0);
    repeat (6) @(negedge clock);
    chk(got, 44'h0, "held in reset");
    rst_n = 1'b1;
    $display("test reset done");
    for (int k = 0; k < 64; k++) step(k);
    step(5);
    $display("test sweep done");
    rst_n = 1'b0;
    #1 chk(got, 44'h0, "async reset");
    armed = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    for (int k = 36; k < 46; k++) step(k);
    step(0);
    $display("test midreset done");
    test_done();
  end
endmodule // tb_top
